// File: src/sewc_defines.vh
`ifndef SEWC_DEFINES_VH
`define SEWC_DEFINES_VH

// ****************************************
// Register addresses on the 4-bit port
// ****************************************
`define SEWC_ADDR_VIDEO        4'h0
`define SEWC_ADDR_EXPOSURE     4'h2
`define SEWC_ADDR_GAIN         4'h3
`define SEWC_ADDR_DIVIDER      4'h4
`define SEWC_ADDR_MISC         4'h5
`define SEWC_ADDR_HWIN         4'h6
`define SEWC_ADDR_VWIN         4'h7

// ****************************************
// Reset values
// ****************************************
`define SEWC_RST_EXPOSURE      8'h00
`define SEWC_RST_GAIN          8'h00
`define SEWC_RST_DIVIDER       8'h00
`define SEWC_RST_MISC          8'h00
`define SEWC_RST_HWIN          8'h00
`define SEWC_RST_VWIN          8'h00

// ****************************************
// Field positions
// ****************************************
`define SEWC_EXP_AUTO_BIT      7
`define SEWC_GAIN_MSB          2
`define SEWC_DIV_MSB           5
`define SEWC_MISC_GAMMA        7
`define SEWC_MISC_FLIP         6
`define SEWC_MISC_INDOOR       5
`define SEWC_MISC_BACKLIGHT    4
`define SEWC_MISC_HOLD         3
`define SEWC_MISC_PCLK_GATE    2
`define SEWC_MISC_PCLK_INV     1
`define SEWC_MISC_SHARP_BYP    0

// ****************************************
// Raster geometry, in pixel ticks and lines
// ****************************************
`define SEWC_H_TOTAL           9'd458
`define SEWC_V_TOTAL           10'd625
`define SEWC_H_ACTIVE          9'd384
`define SEWC_V_ACTIVE          10'd288
`define SEWC_BLOCK_W           9'd24
`define SEWC_BLOCK_H           10'd18
`define SEWC_LAST_BLOCK        4'hF

// ****************************************
// Auto exposure
// ****************************************
`define SEWC_AE_BRIGHT_LEVEL   8'h80
`define SEWC_AE_MARGIN         17'h02000
`define SEWC_EXP_MAX           7'h7F
`define SEWC_GAIN_MAX          3'h7

`endif

// File: src/sewc_tick_div.v
`timescale 1ns/100ps

// ****************************************
// Pixel tick divider: one pulse every divisor+1 clocks
// ****************************************
module sewc_tick_div #(
  parameter WIDTH = 6
) (
  input  wire             mclk,
  input  wire             arst_n,
  input  wire [WIDTH-1:0] divisor,
  output reg              tick
);

  reg [WIDTH-1:0] count;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b0;
    end else if (count >= divisor) begin
      count <= {WIDTH{1'b0}};
      tick  <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule

// File: src/sewc_raster.v
`timescale 1ns/100ps
`include "sewc_defines.vh"

// ****************************************
// Line and frame counters driven by the pixel tick
// ****************************************
module sewc_raster (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire       tick,
  output reg  [8:0] hpos,
  output reg  [9:0] vpos,
  output reg        frame_start
);

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      hpos        <= 9'h000;
      vpos        <= 10'h000;
      frame_start <= 1'b0;
    end else begin
      frame_start <= 1'b0;
      if (tick) begin
        if (hpos == `SEWC_H_TOTAL - 9'd1) begin
          hpos <= 9'h000;
          if (vpos == `SEWC_V_TOTAL - 10'd1) begin
            vpos        <= 10'h000;
            frame_start <= 1'b1;
          end else begin
            vpos <= vpos + 10'd1;
          end
        end else begin
          hpos <= hpos + 9'd1;
        end
      end
    end
  end

endmodule

// File: src/sewc_top.v
`timescale 1ns/100ps
`include "sewc_defines.vh"

module sewc_top (
  input  wire       mclk,
  input  wire       arst_n,
  input  wire       cs_n,
  input  wire       we_n,
  input  wire       oe_n,
  input  wire [3:0] addr,
  input  wire [7:0] data_in,
  output reg  [7:0] data_out,
  output reg        data_oe,
  input  wire [7:0] pixel_sample,
  output reg  [8:0] col_addr,
  output reg  [8:0] row_addr,
  output reg  [7:0] pixel_data,
  output reg        line_valid,
  output reg        frame_sync,
  output reg        pixclk,
  output reg  [6:0] exposure_time_code,
  output reg  [2:0] gain_code,
  output reg        indoor_select,
  output reg        backlight_comp
);

  // ****************************************
  // Functions
  // ****************************************
  // Quotient above 15 only outside the active area, where it is masked
  function [3:0] block_of;
    input [9:0] pos;
    input [9:0] size;
    reg   [9:0] quot;
    begin
      quot     = pos / size;
      block_of = quot[3:0];
    end
  endfunction

  // Window spans start..end; an end before the start runs to the last block
  function in_span;
    input [3:0] blk;
    input [7:0] win;
    reg   [3:0] last;
    begin
      last    = (win[3:0] < win[7:4]) ? `SEWC_LAST_BLOCK : win[3:0];
      in_span = (blk >= win[7:4]) && (blk <= last);
    end
  endfunction

  // Piecewise approximation of a 0.45 power curve
  function [7:0] gamma_curve;
    input [7:0] x;
    reg   [9:0] y;
    begin
      if (x < 8'h10) begin
        y = {x, 2'b00};
      end else if (x < 8'h40) begin
        y = 10'd60 + (({2'b00, x} - 10'd16) * 10'd3 >> 1);
      end else begin
        y = 10'd130 + (({2'b00, x} - 10'd64) * 10'd5 >> 3);
      end
      gamma_curve = (y > 10'd255) ? 8'hFF : y[7:0];
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [1:0] cs_sync;
  reg [1:0] we_sync;
  reg [1:0] oe_sync;
  reg [3:0] addr_m;
  reg [3:0] addr_s;
  reg [7:0] din_m;
  reg [7:0] din_s;
  reg       we_prev;
  reg       cs_prev;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cs_sync <= 2'b11;
      we_sync <= 2'b11;
      oe_sync <= 2'b11;
      addr_m  <= 4'h0;
      addr_s  <= 4'h0;
      din_m   <= 8'h00;
      din_s   <= 8'h00;
      we_prev <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_sync <= {cs_sync[0], cs_n};
      we_sync <= {we_sync[0], we_n};
      oe_sync <= {oe_sync[0], oe_n};
      addr_m  <= addr;
      addr_s  <= addr_m;
      din_m   <= data_in;
      din_s   <= din_m;
      we_prev <= we_sync[1];
      cs_prev <= cs_sync[1];
    end
  end

  // Write lands on the rising edge of write enable, so data has settled
  wire wr_strobe = we_sync[1] && !we_prev && !cs_prev;

  // ****************************************
  // Register file
  // ****************************************
  reg [7:0] exposure_control;
  reg [7:0] gain_control;
  reg [7:0] frame_rate_divider;
  reg [7:0] misc_control;
  reg [7:0] horizontal_window;
  reg [7:0] vertical_window;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      exposure_control   <= `SEWC_RST_EXPOSURE;
      gain_control       <= `SEWC_RST_GAIN;
      frame_rate_divider <= `SEWC_RST_DIVIDER;
      misc_control       <= `SEWC_RST_MISC;
      horizontal_window  <= `SEWC_RST_HWIN;
      vertical_window    <= `SEWC_RST_VWIN;
    end else if (wr_strobe) begin
      case (addr_s)
        `SEWC_ADDR_EXPOSURE: exposure_control   <= din_s;
        `SEWC_ADDR_GAIN:     gain_control       <= {5'h00, din_s[`SEWC_GAIN_MSB:0]};
        `SEWC_ADDR_DIVIDER:  frame_rate_divider <= {2'b00, din_s[`SEWC_DIV_MSB:0]};
        `SEWC_ADDR_MISC:     misc_control       <= din_s;
        `SEWC_ADDR_HWIN:     horizontal_window  <= din_s;
        `SEWC_ADDR_VWIN:     vertical_window    <= din_s;
        default: begin
        end
      endcase
    end
  end

  // Unimplemented bits and addresses read as zero; address 0 shows the live byte
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= !cs_sync[1] && !oe_sync[1] && we_sync[1];
      case (addr_s)
        `SEWC_ADDR_VIDEO:    data_out <= pixel_data;
        `SEWC_ADDR_EXPOSURE: data_out <= exposure_control;
        `SEWC_ADDR_GAIN:     data_out <= gain_control;
        `SEWC_ADDR_DIVIDER:  data_out <= frame_rate_divider;
        `SEWC_ADDR_MISC:     data_out <= misc_control;
        `SEWC_ADDR_HWIN:     data_out <= horizontal_window;
        `SEWC_ADDR_VWIN:     data_out <= vertical_window;
        default:             data_out <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Frame-aligned shadow of settings
  // ****************************************
  // Divider and window changes take hold at a frame start so no frame is split between two settings
  wire       frame_start;
  reg  [5:0] divisor_live;
  reg  [7:0] hwin_live;
  reg  [7:0] vwin_live;

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      divisor_live <= 6'h00;
      hwin_live    <= `SEWC_RST_HWIN;
      vwin_live    <= `SEWC_RST_VWIN;
    end else if (frame_start) begin
      divisor_live <= frame_rate_divider[`SEWC_DIV_MSB:0];
      hwin_live    <= horizontal_window;
      vwin_live    <= vertical_window;
    end
  end

  // ****************************************
  // Timing
  // ****************************************
  wire       tick;
  wire [8:0] hpos;
  wire [9:0] vpos;

  // Tick every divisor+1 clocks; pixel clock toggles per tick, but stops outside the window while the gate bit is set
  sewc_tick_div #(
    .WIDTH (6)
  ) u_div (
    .mclk    (mclk),
    .arst_n  (arst_n),
    .divisor (divisor_live),
    .tick    (tick)
  );

  // 458 ticks by 625 lines per frame
  sewc_raster u_raster (
    .mclk        (mclk),
    .arst_n      (arst_n),
    .tick        (tick),
    .hpos        (hpos),
    .vpos        (vpos),
    .frame_start (frame_start)
  );

  wire active = (hpos < `SEWC_H_ACTIVE) && (vpos < `SEWC_V_ACTIVE);
  wire [3:0] hblk = block_of({1'b0, hpos}, {1'b0, `SEWC_BLOCK_W});
  wire [3:0] vblk = block_of(vpos, `SEWC_BLOCK_H);
  wire in_window = active && in_span(hblk, hwin_live) && in_span(vblk, vwin_live);

  // ****************************************
  // Pixel path
  // ****************************************
  wire flip  = misc_control[`SEWC_MISC_FLIP];
  reg  window_d;
  reg  [7:0] prev_pix;
  reg  next_pclk;
  reg  pclk_phase;

  wire [7:0] toned = misc_control[`SEWC_MISC_GAMMA] ? gamma_curve(pixel_sample) : pixel_sample;
  wire signed [9:0] edge_term = ($signed({2'b00, toned}) - $signed({2'b00, prev_pix})) >>> 1;
  wire signed [9:0] sharp_val = $signed({2'b00, toned}) + edge_term;
  wire [7:0] sharpened = sharp_val[9] ? 8'h00 : (sharp_val[8] ? 8'hFF : sharp_val[7:0]);
  wire [7:0] out_pix = misc_control[`SEWC_MISC_SHARP_BYP] ? toned : sharpened;

  always @* begin
    next_pclk = pclk_phase;
    if (tick) begin
      if (!misc_control[`SEWC_MISC_PCLK_GATE] || in_window || window_d) begin
        next_pclk = !pclk_phase;
      end else begin
        next_pclk = 1'b0;
      end
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      col_addr   <= 9'h000;
      row_addr   <= 9'h000;
      pixel_data <= 8'h00;
      line_valid <= 1'b0;
      frame_sync <= 1'b0;
      window_d   <= 1'b0;
      prev_pix   <= 8'h00;
      pclk_phase <= 1'b0;
      pixclk     <= 1'b0;
    end else begin
      pclk_phase <= next_pclk;
      pixclk     <= next_pclk ^ misc_control[`SEWC_MISC_PCLK_INV];
      if (tick) begin
        // Address this tick, sample returns for the next one
        col_addr   <= (flip && active) ? (`SEWC_H_ACTIVE - 9'd1 - hpos) : hpos;
        row_addr   <= vpos[8:0];
        window_d   <= in_window;
        // Data keeps flowing outside the window; only line_valid qualifies it
        pixel_data <= out_pix;
        prev_pix   <= toned;
        line_valid <= window_d;
        frame_sync <= (vpos == 10'd0);
      end
    end
  end

  // ****************************************
  // Exposure and gain
  // ****************************************
  wire auto_mode = exposure_control[`SEWC_EXP_AUTO_BIT];
  wire hold      = misc_control[`SEWC_MISC_HOLD];
  reg  [16:0] bright_cnt;
  reg  [16:0] dark_cnt;
  reg  [6:0]  ae_exposure;
  reg  [2:0]  ae_gain;

  // Crude brightness balance: whole image counted, as the metering ignores the window
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bright_cnt  <= 17'h00000;
      dark_cnt    <= 17'h00000;
      ae_exposure <= `SEWC_EXP_MAX;
      ae_gain     <= 3'h0;
    end else if (frame_start) begin
      bright_cnt <= 17'h00000;
      dark_cnt   <= 17'h00000;
      if (auto_mode && !hold) begin
        if (bright_cnt > dark_cnt + `SEWC_AE_MARGIN) begin
          if (ae_gain != 3'h0) begin
            ae_gain <= ae_gain - 3'd1;
          end else if (ae_exposure != 7'h00) begin
            ae_exposure <= ae_exposure - 7'd1;
          end
        end else if (dark_cnt > bright_cnt + `SEWC_AE_MARGIN) begin
          if (ae_exposure != `SEWC_EXP_MAX) begin
            ae_exposure <= ae_exposure + 7'd1;
          end else if (ae_gain != `SEWC_GAIN_MAX) begin
            ae_gain <= ae_gain + 3'd1;
          end
        end
      end
    end else if (tick && active) begin
      if (pixel_sample >= `SEWC_AE_BRIGHT_LEVEL) begin
        bright_cnt <= bright_cnt + 17'd1;
      end else begin
        dark_cnt <= dark_cnt + 17'd1;
      end
    end
  end

  // Exposure and gain codes update once per frame, settled well inside two frames; indoor and backlight follow the register at once
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      exposure_time_code <= 7'h00;
      gain_code          <= 3'h0;
      indoor_select      <= 1'b0;
      backlight_comp     <= 1'b0;
    end else begin
      indoor_select  <= misc_control[`SEWC_MISC_INDOOR];
      backlight_comp <= misc_control[`SEWC_MISC_BACKLIGHT];
      if (frame_start) begin
        if (auto_mode) begin
          exposure_time_code <= ae_exposure;
          gain_code          <= ae_gain;
        end else begin
          exposure_time_code <= exposure_control[6:0];
          gain_code          <= gain_control[`SEWC_GAIN_MSB:0];
        end
      end
    end
  end

endmodule

// File: tb/sewc_video_model.sv
`timescale 1ns/100ps

// ****************************************
// Sensor core and capture side
// ****************************************
module sewc_video_model (
  input  wire        mclk,
  input  wire        arst_n,
  input  wire  [8:0] col_addr,
  input  wire  [8:0] row_addr,
  input  wire        line_valid,
  output wire  [7:0] pixel_sample,
  output logic [8:0] line_bytes,
  output logic [9:0] valid_lines
);
  logic [8:0] run;
  logic       lv_d;

  // Byte depends on position, so a stuck address shows up
  assign pixel_sample = col_addr[7:0] ^ {row_addr[3:0], 4'h0};

  // One byte per mclk: only right at divider 0
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      run         <= 9'h000;
      lv_d        <= 1'b0;
      line_bytes  <= 9'h000;
      valid_lines <= 10'h000;
    end else begin
      lv_d <= line_valid;
      if (line_valid) begin
        run <= run + 9'h001;
      end else begin
        run <= 9'h000;
      end
      if (lv_d && !line_valid) begin
        line_bytes <= run;
      end
      if (line_valid && !lv_d) begin
        valid_lines <= valid_lines + 10'h001;
      end
    end
  end
endmodule

// File: tb/sewc_top_monitor.sv
`timescale 1ns/100ps
`include "sewc_defines.vh"

// ****************************************
// Port checker
// ****************************************
module sewc_top_monitor (
  input wire       mclk,
  input wire       arst_n,
  input wire [3:0] addr,
  input wire [7:0] data_out,
  input wire       data_oe,
  input wire [8:0] col_addr,
  input wire [8:0] row_addr,
  input wire       line_valid,
  input wire       frame_sync,
  input wire [6:0] exposure_time_code,
  input wire [2:0] gain_code,
  input wire       indoor_select,
  input wire       backlight_comp
);
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!arst_n);

  chk_gain_width:
    assert property (data_oe && $past(addr, 3) == `SEWC_ADDR_GAIN |-> data_out[7:3] == 5'h00)
    else $error("gain read shows bits above the code");
  chk_div_range:
    assert property (data_oe && $past(addr, 3) == `SEWC_ADDR_DIVIDER |-> data_out[7:6] == 2'h0)
    else $error("divider read above 63");
  chk_misc_copy:
    assert property (data_oe && $past(addr, 3) == `SEWC_ADDR_MISC |->
                     data_out[5:4] == {indoor_select, backlight_comp})
    else $error("indoor or backlight output differs from register");
  chk_line_len:
    assert property (col_addr <= 9'd457)
    else $error("column beyond line length");
  chk_lv_rows:
    assert property (line_valid |-> row_addr < 9'd288)
    else $error("line valid outside active lines");
  chk_lv_cols:
    assert property (line_valid |-> col_addr <= 9'd385)
    else $error("line valid outside active columns");
  chk_fsync_row:
    assert property (frame_sync |-> row_addr == 9'd0)
    else $error("frame sync away from line zero");
  chk_fsync_quiet:
    assert property ($rose(frame_sync) |-> !line_valid)
    else $error("line valid at frame start");
  chk_code_update:
    assert property ($changed({exposure_time_code, gain_code}) |-> ##[0:70] frame_sync)
    else $error("exposure or gain changed away from frame start");

  cov_read: cover property (data_oe);
  cov_line: cover property ($rose(line_valid));
  cov_frame: cover property ($rose(frame_sync));
endmodule

bind sewc_top sewc_top_monitor i_mon (
  .mclk               (mclk),
  .arst_n             (arst_n),
  .addr               (addr),
  .data_out           (data_out),
  .data_oe            (data_oe),
  .col_addr           (col_addr),
  .row_addr           (row_addr),
  .line_valid         (line_valid),
  .frame_sync         (frame_sync),
  .exposure_time_code (exposure_time_code),
  .gain_code          (gain_code),
  .indoor_select      (indoor_select),
  .backlight_comp     (backlight_comp)
);

// File: tb/sewc_top_tb.sv
`timescale 1ns/100ps
`include "sewc_defines.vh"

// ****************************************
// Register and video bench
// ****************************************
module sewc_top_tb;
  logic       mclk    = 1'b0;
  logic       arst_n  = 1'b0;
  logic       cs_n    = 1'b1;
  logic       we_n    = 1'b1;
  logic       oe_n    = 1'b1;
  logic [3:0] addr    = 4'h0;
  logic [7:0] data_in = 8'h00;
  logic [7:0] rd;
  wire  [7:0] data_out, pixel_data, pixel_sample;
  wire  [8:0] col_addr, row_addr, line_bytes;
  wire  [9:0] valid_lines;
  wire  [6:0] exposure_time_code;
  wire  [2:0] gain_code;
  wire        data_oe, line_valid, frame_sync, pixclk, indoor_select, backlight_comp;
  int         error_cnt = 0;
  int         checked   = 0;
  int         t0, c;
  logic [3:0] ta [7] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8};
  logic [7:0] td [7] = '{8'hA5, 8'hFF, 8'hFF, 8'h30, 8'h4C, 8'h44, 8'h55};
  logic [7:0] te [7] = '{8'hA5, 8'h07, 8'h3F, 8'h30, 8'h4C, 8'h44, 8'h00};

  always #5 mclk = ~mclk;

  sewc_top i_dut (.mclk(mclk), .arst_n(arst_n), .cs_n(cs_n), .we_n(we_n), .oe_n(oe_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .pixel_sample(pixel_sample),
    .col_addr(col_addr), .row_addr(row_addr), .pixel_data(pixel_data), .line_valid(line_valid),
    .frame_sync(frame_sync), .pixclk(pixclk), .exposure_time_code(exposure_time_code),
    .gain_code(gain_code), .indoor_select(indoor_select), .backlight_comp(backlight_comp));

  sewc_video_model i_far (.mclk(mclk), .arst_n(arst_n), .col_addr(col_addr), .row_addr(row_addr),
    .line_valid(line_valid), .pixel_sample(pixel_sample), .line_bytes(line_bytes),
    .valid_lines(valid_lines));

  task automatic cmp_reg(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_cnt(string what, logic [15:0] exp, logic [15:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic tick(int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  // Pins are synchronised inside, so every phase is held several clocks
  task automatic wr(logic [3:0] a, logic [7:0] d);
    cs_n = 1'b0;
    addr = a;
    data_in = d;
    we_n = 1'b0;
    tick(4);
    we_n = 1'b1;
    tick(4);
    cs_n = 1'b1;
    tick(2);
  endtask

  task automatic rd_reg(logic [3:0] a);
    cs_n = 1'b0;
    oe_n = 1'b0;
    addr = a;
    tick(4);
    cmp_reg("data_oe", 8'h01, {7'h00, data_oe});
    rd = data_out;
    oe_n = 1'b1;
    cs_n = 1'b1;
    tick(4);
  endtask

  task automatic wait_lv(logic lvl);
    int n;
    n = 0;
    while (line_valid !== lvl && n < 2000) begin
      tick(1);
      n++;
    end
    if (n >= 2000) begin
      error_cnt++;
      $display("unexpected line_valid wait expected %b seen timeout", lvl);
      test_done;
    end
  endtask

  task automatic wait_col0();
    int n;
    n = 0;
    while (col_addr !== 9'h000 && n < 500) begin
      tick(1);
      n++;
    end
    if (n >= 500) begin
      error_cnt++;
      $display("unexpected col_addr wait expected 000 seen timeout");
      test_done;
    end
  endtask

  task automatic count_pclk();
    logic p;
    c = 0;
    p = pixclk;
    repeat (100) begin
      tick(1);
      if (pixclk !== p) c++;
      p = pixclk;
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    tick(16);
    arst_n = 1'b1;
    tick(1);
    for (int i = 0; i < 6; i++) begin
      rd_reg(ta[i]);
      cmp_reg("reset value", 8'h00, rd);
    end
    $display("test reset values done");
    for (int i = 0; i < 7; i++) begin
      wr(ta[i], td[i]);
      rd_reg(ta[i]);
      cmp_reg("read back", te[i], rd);
    end
    cmp_reg("indoor and backlight", 8'h03, {6'h00, indoor_select, backlight_comp});
    $display("test register access done");
    // Mid-run reset restarts the raster at line zero with the reset window
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    cmp_reg("indoor and backlight after reset", 8'h00, {6'h00, indoor_select, backlight_comp});
    wait_lv(1'b1);
    cmp_reg("frame sync in first line", 8'h01, {7'h00, frame_sync});
    t0 = $time;
    wait_lv(1'b0);
    wait_lv(1'b1);
    cmp_cnt("line period", 16'd458, 16'(($time - t0) / 10));
    cmp_reg("frame sync in second line", 8'h00, {7'h00, frame_sync});
    wait_lv(1'b0);
    tick(2);
    cmp_cnt("bytes per line", 16'd24, {7'h00, line_bytes});
    tick(458 * 24);
    cmp_cnt("lines in window", 16'd18, {6'h00, valid_lines});
    $display("test window timing done");
    wr(`SEWC_ADDR_MISC, 8'h06);
    tick(8);
    count_pclk();
    cmp_cnt("gated clock edges", 16'd0, 16'(c));
    cmp_reg("gated clock level", 8'h01, {7'h00, pixclk});
    wr(`SEWC_ADDR_MISC, 8'h01);
    tick(8);
    count_pclk();
    cmp_cnt("free clock edges", 16'd100, 16'(c));
    $display("test pixel clock done");
    rd = col_addr[7:0] ^ {row_addr[3:0], 4'h0};
    tick(1);
    cmp_reg("pixel byte", rd, pixel_data);
    wr(`SEWC_ADDR_MISC, 8'h41);
    tick(8);
    wait_col0();
    tick(1);
    cmp_cnt("column after mirrored zero", 16'd384, {7'h00, col_addr});
    $display("test pixel path done");
    test_done;
  end
endmodule
